// ==== core/inband_mgmt_map.vh ====
// Contract
// - bit 31 set on good management frame
// - bit 30 set when reply frame sent
// - bit 29 set when all commands executed
// - matching tag clears bits 30 to 10
// - bit 14 destination mismatch only when checking
// - bit 13 set when format not 0x9800
// - bit 12 set unless code 0x0001/0x0002
// - bit 11 set on unknown command code
// - frame limit 320 bytes including padding, FCS
// - oversize sets bit 10, no response
// - bits 6:0 give bad command location
// - control bit 30 enables destination discard
// - control bit 29 initialises engine, self-clears
// - frame type value programmable, default 0x40fe
`ifndef INBAND_MGMT_MAP_VH
`define INBAND_MGMT_MAP_VH

`define MGMT_CTRL_ADDR     16'h0104
`define MGMT_STATUS_ADDR   16'h0110

`define CTRL_ENABLE_BIT    31
`define CTRL_DACHECK_BIT   30
`define CTRL_INIT_BIT      29
`define CTRL_QUEUE_HI      23
`define CTRL_QUEUE_LO      22
`define CTRL_PORT_HI       18
`define CTRL_PORT_LO       16
`define CTRL_TPID_HI       15
`define CTRL_TPID_LO       0

`define CTRL_QUEUE_RESET   2'h1
`define CTRL_PORT_RESET    3'h0
`define CTRL_TPID_RESET    16'h40fe

`define ST_GOOD_BIT        31
`define ST_RESP_BIT        30
`define ST_EXEC_BIT        29
`define ST_DA_BIT          14
`define ST_FMT_BIT         13
`define ST_CODE_BIT        12
`define ST_CMD_BIT         11
`define ST_OVER_BIT        10
`define ST_LOC_HI          6
`define ST_LOC_LO          0
`define ST_LOC_W           7

`define ACCESS_FORMAT      16'h9800
`define ACCESS_CODE_A      16'h0001
`define ACCESS_CODE_B      16'h0002

// frame limit counts the zero padding ahead of the check sequence and
// the check sequence itself
`define FRAME_MAX_BYTES    9'h140
`define POS_SAT            9'h1ff
`define POS_DA_LAST        9'h005
`define POS_TYPE_HI        9'h00c
`define POS_TYPE_LO        9'h00d
`define POS_FMT_HI         9'h010
`define POS_FMT_LO         9'h011
`define POS_CODE_HI        9'h012
`define POS_CODE_LO        9'h013

`define STRAP_WAIT_DONE    2'h3

`endif

// ==== core/sync_two_ff.v ====
`timescale 1ns/10ps
`default_nettype none
module sync_two_ff (
  // clock and reset
  input  wire i_clk,
  input  wire i_rst_b,
  // asynchronous level in, synchronised level out
  input  wire i_async,
  output reg  o_sync
);

  reg meta;

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule
`default_nettype wire

// ==== core/frame_length_counter.v ====
`timescale 1ns/10ps
`default_nettype none
`include "inband_mgmt_map.vh"
module frame_length_counter (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst_b,
  // byte strobes
  input  wire       i_clear,
  input  wire       i_start,
  input  wire       i_step,
  // position of the current byte and oversize state
  output wire [8:0] o_pos,
  output reg        o_over
);

  reg  [8:0] cnt;
  wire [8:0] next_cnt;

  assign o_pos    = i_start ? 9'h000 : cnt;
  // saturate so a runaway frame cannot wrap back under the limit
  assign next_cnt = (o_pos == `POS_SAT) ? `POS_SAT : o_pos + 9'h001;

  always @(posedge i_clk) begin
    if (!i_rst_b || i_clear) begin
      cnt    <= 9'h000;
      o_over <= 1'b0;
    end else if (i_step) begin
      cnt    <= next_cnt;
      o_over <= (o_over & ~i_start) | (next_cnt > `FRAME_MAX_BYTES);
    end
  end

endmodule
`default_nettype wire

// ==== core/inband_mgmt_status_flags.v ====
`timescale 1ns/10ps
`default_nettype none
`include "inband_mgmt_map.vh"
module inband_mgmt_status_flags (
  // clock and reset
  input  wire        I_CLK_SYS,
  input  wire        I_RST_B,
  // enable strap pin
  input  wire        I_STRAP_ENABLE,
  // register access port
  input  wire [15:0] I_REG_ADDR,
  input  wire        I_REG_WR,
  input  wire        I_REG_RD,
  input  wire [31:0] I_REG_WDATA,
  output reg  [31:0] O_REG_RDATA,
  output reg         O_REG_RVALID,
  // switch address from the switch registers
  input  wire [47:0] I_SWITCH_MAC,
  // received byte stream from the management port
  input  wire        I_RX_VALID,
  input  wire        I_RX_SOF,
  input  wire        I_RX_EOF,
  input  wire [7:0]  I_RX_DATA,
  input  wire        I_RX_GOOD,
  // events from the rest of the engine
  input  wire        I_TAG_MATCH,
  input  wire        I_CMD_STROBE,
  input  wire        I_CMD_KNOWN,
  input  wire [6:0]  I_CMD_LOC,
  input  wire        I_EXEC_DONE,
  input  wire        I_RESP_SENT,
  // hand-off to the rest of the engine
  output reg         O_FRAME_ACCEPT,
  output reg         O_FRAME_DISCARD,
  output reg         O_FRAME_OVERSIZE,
  output reg         O_ENGINE_INIT,
  // configuration seen by the rest of the engine
  output reg         O_MGMT_ENABLE,
  output reg  [1:0]  O_RESP_QUEUE,
  output reg  [2:0]  O_MGMT_PORT,
  output reg  [15:0] O_FRAME_TYPE
);

  // control register fields and strap capture state
  reg         dest_address_check_enable;
  reg         init_req;
  reg  [1:0]  strap_wait;
  wire        strap_sync;

  // status flags
  reg         good_seen;
  reg         resp_done;
  reg         exec_done;
  reg         err_da;
  reg         err_fmt;
  reg         err_code;
  reg         err_cmd;
  reg         err_over;
  reg  [6:0]  cmd_loc;

  // frame parser state
  reg         frame_open;
  reg         da_mismatch;
  reg  [15:0] type_field;
  reg  [15:0] fmt_field;
  reg  [15:0] code_field;
  reg         end_pend;
  reg         end_good;
  reg         exec_pend;
  reg         resp_pend;
  wire [8:0]  pos;
  wire        over;
  wire        take_byte;

  // evaluation terms
  wire        is_mgmt;
  wire        da_bad;
  wire        fmt_bad;
  wire        code_bad;
  wire        frame_bad;
  wire        set_good;
  wire        set_da;
  wire        set_fmt;
  wire        set_code;
  wire        set_over;
  wire        set_cmd;
  wire        set_exec;
  wire        set_resp;
  wire        clr_err;
  wire [31:0] ctrl_word;
  wire [31:0] status_word;

  function [7:0] mac_byte;
    input [47:0] mac;
    input [8:0]  idx;
    begin
      case (idx)
        9'h000:  mac_byte = mac[47:40];
        9'h001:  mac_byte = mac[39:32];
        9'h002:  mac_byte = mac[31:24];
        9'h003:  mac_byte = mac[23:16];
        9'h004:  mac_byte = mac[15:8];
        default: mac_byte = mac[7:0];
      endcase
    end
  endfunction

  // big-endian capture of a two-byte header field
  function [15:0] put_byte;
    input [15:0] old;
    input [8:0]  idx;
    input [8:0]  hi_idx;
    input [7:0]  data;
    begin
      if (idx == hi_idx)
        put_byte = {data, old[7:0]};
      else if (idx == hi_idx + 9'h001)
        put_byte = {old[15:8], data};
      else
        put_byte = old;
    end
  endfunction

  sync_two_ff u_strap_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst_b (I_RST_B),
    .i_async (I_STRAP_ENABLE),
    .o_sync  (strap_sync)
  );

  assign take_byte = I_RX_VALID & (I_RX_SOF | frame_open) & ~init_req;

  frame_length_counter u_len (
    .i_clk   (I_CLK_SYS),
    .i_rst_b (I_RST_B),
    .i_clear (init_req),
    .i_start (I_RX_SOF),
    .i_step  (take_byte),
    .o_pos   (pos),
    .o_over  (over)
  );

  // ---- control register, strap capture and engine init
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_MGMT_ENABLE             <= 1'b0;
      dest_address_check_enable <= 1'b0;
      init_req                  <= 1'b0;
      O_RESP_QUEUE              <= `CTRL_QUEUE_RESET;
      O_MGMT_PORT               <= `CTRL_PORT_RESET;
      O_FRAME_TYPE              <= `CTRL_TPID_RESET;
      strap_wait                <= 2'h0;
    end else begin
      init_req <= 1'b0;
      // the strap passes the synchroniser before it is caught, so wait
      // for it to settle after reset release
      if (strap_wait != `STRAP_WAIT_DONE) begin
        strap_wait <= strap_wait + 2'h1;
        if (strap_wait == `STRAP_WAIT_DONE - 2'h1)
          O_MGMT_ENABLE <= strap_sync;
      end
      if (I_REG_WR && I_REG_ADDR == `MGMT_CTRL_ADDR) begin
        O_MGMT_ENABLE             <= I_REG_WDATA[`CTRL_ENABLE_BIT];
        dest_address_check_enable <= I_REG_WDATA[`CTRL_DACHECK_BIT];
        init_req                  <= I_REG_WDATA[`CTRL_INIT_BIT];
        O_RESP_QUEUE  <= I_REG_WDATA[`CTRL_QUEUE_HI:`CTRL_QUEUE_LO];
        O_MGMT_PORT   <= I_REG_WDATA[`CTRL_PORT_HI:`CTRL_PORT_LO];
        O_FRAME_TYPE  <= I_REG_WDATA[`CTRL_TPID_HI:`CTRL_TPID_LO];
      end
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RST_B)
      O_ENGINE_INIT <= 1'b0;
    else
      O_ENGINE_INIT <= init_req;
  end

  // ---- header parser
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_B || init_req) begin
      frame_open  <= 1'b0;
      da_mismatch <= 1'b0;
      type_field  <= 16'h0000;
      fmt_field   <= 16'h0000;
      code_field  <= 16'h0000;
      end_pend    <= 1'b0;
      end_good    <= 1'b0;
    end else begin
      end_pend <= take_byte & I_RX_EOF;
      end_good <= I_RX_GOOD;
      if (take_byte) begin
        frame_open <= ~I_RX_EOF;
        if (I_RX_SOF) begin
          da_mismatch <= (I_RX_DATA != mac_byte(I_SWITCH_MAC, pos));
          type_field  <= 16'h0000;
          fmt_field   <= 16'h0000;
          code_field  <= 16'h0000;
        end else begin
          if (pos <= `POS_DA_LAST &&
              I_RX_DATA != mac_byte(I_SWITCH_MAC, pos))
            da_mismatch <= 1'b1;
          type_field <= put_byte(type_field, pos, `POS_TYPE_HI, I_RX_DATA);
          fmt_field  <= put_byte(fmt_field, pos, `POS_FMT_HI, I_RX_DATA);
          code_field <= put_byte(code_field, pos, `POS_CODE_HI, I_RX_DATA);
        end
      end
    end
  end

  // ---- end-of-frame verdict, one cycle after the last byte
  assign is_mgmt  = end_pend & end_good & O_MGMT_ENABLE &
                    (type_field == O_FRAME_TYPE);
  assign da_bad   = dest_address_check_enable & da_mismatch;
  assign fmt_bad  = (fmt_field != `ACCESS_FORMAT);
  assign code_bad = (code_field != `ACCESS_CODE_A) &&
                    (code_field != `ACCESS_CODE_B);
  // a destination mismatch discards the frame before any field check
  assign set_da    = is_mgmt & da_bad;
  assign set_fmt   = is_mgmt & ~da_bad & fmt_bad;
  assign set_code  = is_mgmt & ~da_bad & code_bad;
  assign set_over  = is_mgmt & ~da_bad & over;
  assign frame_bad = da_bad | fmt_bad | code_bad | over;
  assign set_good  = is_mgmt & ~frame_bad;
  assign set_cmd   = I_CMD_STROBE & ~I_CMD_KNOWN & exec_pend;
  assign set_exec  = I_EXEC_DONE & exec_pend;
  assign set_resp  = I_RESP_SENT & resp_pend;
  assign clr_err   = I_TAG_MATCH;

  always @(posedge I_CLK_SYS) begin
    if (!I_RST_B || init_req) begin
      O_FRAME_ACCEPT   <= 1'b0;
      O_FRAME_DISCARD  <= 1'b0;
      O_FRAME_OVERSIZE <= 1'b0;
      exec_pend        <= 1'b0;
      resp_pend        <= 1'b0;
    end else begin
      O_FRAME_ACCEPT   <= set_good;
      O_FRAME_DISCARD  <= set_da;
      O_FRAME_OVERSIZE <= set_over;
      // only an accepted frame may later report execution or a reply
      exec_pend <= set_good | (exec_pend & ~I_EXEC_DONE);
      resp_pend <= set_good | (resp_pend & ~I_RESP_SENT);
    end
  end

  // ---- status flags; a set in the clearing cycle wins over the clear
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_B || init_req) begin
      good_seen <= 1'b0;
      resp_done <= 1'b0;
      exec_done <= 1'b0;
      err_da    <= 1'b0;
      err_fmt   <= 1'b0;
      err_code  <= 1'b0;
      err_cmd   <= 1'b0;
      err_over  <= 1'b0;
      cmd_loc   <= 7'h00;
    end else begin
      good_seen <= good_seen | set_good;
      resp_done <= set_resp | (resp_done & ~clr_err);
      exec_done <= set_exec | (exec_done & ~clr_err);
      err_da    <= set_da | (err_da & ~clr_err);
      err_fmt   <= set_fmt | (err_fmt & ~clr_err);
      err_code  <= set_code | (err_code & ~clr_err);
      err_cmd   <= set_cmd | (err_cmd & ~clr_err);
      err_over  <= set_over | (err_over & ~clr_err);
      if (set_cmd)
        cmd_loc <= I_CMD_LOC;
      else if (clr_err)
        cmd_loc <= 7'h00;
    end
  end

  // ---- register read port
  assign ctrl_word = {O_MGMT_ENABLE, dest_address_check_enable, init_req,
                      5'h00, O_RESP_QUEUE, 3'h0, O_MGMT_PORT,
                      O_FRAME_TYPE};
  assign status_word = {good_seen, resp_done, exec_done, 14'h0000,
                        err_da, err_fmt, err_code, err_cmd, err_over,
                        3'h0, cmd_loc};

  // reads have no side effect; writes to the status address are dropped
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_REG_RDATA  <= 32'h00000000;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD) begin
        case (I_REG_ADDR)
          `MGMT_CTRL_ADDR:   O_REG_RDATA <= ctrl_word;
          `MGMT_STATUS_ADDR: O_REG_RDATA <= status_word;
          default:           O_REG_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/inband_mgmt_status_flags_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module inband_mgmt_status_flags_chk (
  // watched top-level ports
  input wire logic        I_CLK_SYS,
  input wire logic        I_RST_B,
  input wire logic [15:0] I_REG_ADDR,
  input wire logic        I_REG_WR,
  input wire logic        I_REG_RD,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic [31:0] O_REG_RDATA,
  input wire logic        O_REG_RVALID,
  input wire logic        I_RX_VALID,
  input wire logic        I_RX_EOF,
  input wire logic        I_RX_GOOD,
  input wire logic        O_FRAME_ACCEPT,
  input wire logic        O_FRAME_DISCARD,
  input wire logic        O_FRAME_OVERSIZE,
  input wire logic        O_ENGINE_INIT,
  input wire logic [15:0] O_FRAME_TYPE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  sequence s_init_wr;
    I_REG_WR && I_REG_ADDR == 16'h0104 && I_REG_WDATA[29];
  endsequence
  sequence s_init_pulse;
    ##2 O_ENGINE_INIT ##1 !O_ENGINE_INIT;
  endsequence
  property p_init;
    s_init_wr |-> s_init_pulse;
  endproperty
  a_init: assert property (p_init) else $error("init pulse");
  property p_acc;
    O_FRAME_ACCEPT |-> $past(I_RX_VALID && I_RX_EOF && I_RX_GOOD, 2);
  endproperty
  a_acc: assert property (p_acc) else $error("accept timing");
  property p_ovr_t;
    O_FRAME_OVERSIZE |-> $past(I_RX_VALID && I_RX_EOF, 2);
  endproperty
  a_ovr_t: assert property (p_ovr_t) else $error("oversize timing");
  property p_ovr_na;
    O_FRAME_OVERSIZE |-> !O_FRAME_ACCEPT;
  endproperty
  a_ovr_na: assert property (p_ovr_na) else $error("oversize reply");
  property p_dis_na;
    O_FRAME_DISCARD |-> !O_FRAME_ACCEPT;
  endproperty
  a_dis_na: assert property (p_dis_na) else $error("discard accept");
  property p_dis_t;
    O_FRAME_DISCARD |-> $past(I_RX_VALID && I_RX_EOF, 2);
  endproperty
  a_dis_t: assert property (p_dis_t) else $error("discard timing");
  property p_resv;
    O_REG_RVALID && $past(I_REG_ADDR) == 16'h0110 |->
      O_REG_RDATA[28:15] == 14'h0000 && O_REG_RDATA[9:7] == 3'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits");
  property p_type;
    disable iff (1'b0) !I_RST_B |=> O_FRAME_TYPE == 16'h40fe;
  endproperty
  a_type: assert property (p_type) else $error("frame type reset");
endmodule
bind inband_mgmt_status_flags inband_mgmt_status_flags_chk u_chk (
  .I_CLK_SYS, .I_RST_B, .I_REG_ADDR, .I_REG_WR, .I_REG_RD, .I_REG_WDATA,
  .O_REG_RDATA, .O_REG_RVALID, .I_RX_VALID, .I_RX_EOF, .I_RX_GOOD,
  .O_FRAME_ACCEPT, .O_FRAME_DISCARD, .O_FRAME_OVERSIZE, .O_ENGINE_INIT,
  .O_FRAME_TYPE
);
`default_nettype wire

// ==== verification/mgmt_station.sv ====
`timescale 1ns/10ps
`default_nettype none
module mgmt_station (
  // clock
  input  wire logic       i_clk,
  // byte stream towards the switch
  output var  logic       o_valid,
  output var  logic       o_sof,
  output var  logic       o_eof,
  output var  logic       o_good,
  output var  logic [7:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_sof = 1'b0;
    o_eof = 1'b0;
    o_good = 1'b0;
    o_data = 8'h00;
  end
  task automatic send(int n, logic [47:0] da, logic [15:0] fmt, code);
    logic [159:0] hdr;
    hdr = {da, 48'h0a0b0c0d0e0f, 16'h40fe, 16'h0000, fmt, code};
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk) #1;
      o_valid = 1'b1;
      o_sof = (i == 0);
      o_eof = (i == n - 1);
      o_good = (i == n - 1);
      o_data = (i < 20) ? hdr[159 - 8 * i -: 8] : 8'(i);
      if (i >= n - 12 && i < n - 4) o_data = 8'h00;
    end
    @(posedge i_clk) #1;
    o_valid = 1'b0;
    o_eof = 1'b0;
    o_good = 1'b0;
    // idle lane must not look like a held byte
    o_data = ~o_data;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [47:0] own = 48'h020000000001;
  localparam logic [47:0] other = 48'h020000000002;
  localparam logic [15:0] sa = 16'h0110;
  localparam logic [15:0] ca = 16'h0104;
  logic        clk, rst_b, wr, rd, rvalid, vld, sof, eof, good;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0]  data;
  logic [3:0]  ev;
  logic        known, acc, dis, ovr, ena;
  logic [1:0]  q;
  logic [2:0]  port;
  logic [15:0] ftype;
  wire  [31:0] outs = {ena, 7'h00, q, 3'h0, port, ftype};
  int          err_count, total_checks, n_acc, n_dis, n_ovr;
  inband_mgmt_status_flags dut (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_STRAP_ENABLE(1'b1),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_SWITCH_MAC(own),
    .I_RX_VALID(vld), .I_RX_SOF(sof), .I_RX_EOF(eof), .I_RX_DATA(data),
    .I_RX_GOOD(good), .I_TAG_MATCH(ev[0]), .I_CMD_STROBE(ev[1]),
    .I_CMD_KNOWN(known), .I_CMD_LOC(7'h15), .I_EXEC_DONE(ev[2]),
    .I_RESP_SENT(ev[3]), .O_FRAME_ACCEPT(acc), .O_FRAME_DISCARD(dis),
    .O_FRAME_OVERSIZE(ovr), .O_ENGINE_INIT(), .O_MGMT_ENABLE(ena),
    .O_RESP_QUEUE(q), .O_MGMT_PORT(port), .O_FRAME_TYPE(ftype)
  );
  // verdict pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (acc) n_acc <= n_acc + 1;
    if (dis) n_dis <= n_dis + 1;
    if (ovr) n_ovr <= n_ovr + 1;
  end
  mgmt_station st (.i_clk(clk), .o_valid(vld), .o_sof(sof), .o_eof(eof),
    .o_good(good), .o_data(data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string w, logic [31:0] e, a);
    total_checks++;
    if (a !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, a);
    end
  endtask
  task automatic reg_wr(logic [15:0] a, logic [31:0] d);
    @(posedge clk) #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask
  task automatic reg_rd(logic [15:0] a, logic [31:0] e, string w);
    @(posedge clk) #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk(w, e, rdata);
  endtask
  task automatic pulse(logic [3:0] v);
    @(posedge clk) #1;
    ev = v;
    @(posedge clk) #1;
    ev = 4'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic frame(int n, logic [47:0] da, logic [15:0] f, c);
    st.send(n, da, f, c);
    repeat (4) @(posedge clk);
  endtask
  task automatic t_reset;
    reg_rd(sa, 32'h0, "status reset");
    reg_rd(ca, 32'h804040fe, "ctrl reset");
    reg_rd(16'h0200, 32'h0, "unmapped");
    chk("reset outs", 32'h804040fe, outs);
  endtask
  task automatic t_good;
    frame(60, other, 16'h9800, 16'h0001);
    reg_rd(sa, 32'h80000000, "good");
    known = 1'b1;
    pulse(4'h2);
    reg_rd(sa, 32'h80000000, "known cmd");
    known = 1'b0;
    pulse(4'h2);
    reg_rd(sa, 32'h80000815, "cmd");
    pulse(4'h4);
    reg_rd(sa, 32'ha0000815, "exec");
    pulse(4'h8);
    reg_rd(sa, 32'he0000815, "resp");
    reg_wr(sa, 32'h0);
    reg_rd(sa, 32'he0000815, "write");
    pulse(4'h1);
    reg_rd(sa, 32'h80000000, "tag");
  endtask
  task automatic t_errors;
    frame(60, own, 16'h1234, 16'h0003);
    reg_rd(sa, 32'h80003000, "fmt code");
    pulse(4'h1);
    frame(60, own, 16'h9800, 16'h0002);
    reg_rd(sa, 32'h80000000, "code two");
  endtask
  task automatic t_over;
    frame(321, own, 16'h9800, 16'h0001);
    reg_rd(sa, 32'h80000400, "over");
    pulse(4'h1);
    frame(320, own, 16'h9800, 16'h0001);
    reg_rd(sa, 32'h80000000, "max len");
  endtask
  task automatic t_da;
    reg_wr(ca, 32'hc04040fe);
    frame(60, other, 16'h9800, 16'h0001);
    reg_rd(sa, 32'h80004000, "dest");
  endtask
  task automatic t_init;
    reg_wr(ca, 32'ha04040fe);
    repeat (3) @(posedge clk);
    reg_rd(sa, 32'h0, "init status");
    reg_rd(ca, 32'h804040fe, "init ctrl");
    reg_wr(ca, 32'h80c21234);
    frame(60, own, 16'h9800, 16'h0001);
    reg_rd(sa, 32'h0, "type filter");
    chk("new outs", 32'h80c21234, outs);
  endtask
  task automatic t_counts;
    chk("accepts", 32'h3, n_acc);
    chk("discards", 32'h1, n_dis);
    chk("oversizes", 32'h1, n_ovr);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    {wr, rd, addr, wdata, ev, known} = '0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_good;
    t_errors;
    t_over;
    t_da;
    t_init;
    t_counts;
    stop_test;
  end
  // the whole run needs about 1100 cycles
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
